// *** hdl/afpm_pkg.sv ***
// Purpose: constants for the alternate-function pin mux
// Assumes: port config nibbles of four bits per pin
// Notes:   nibble codes are plain defaults, adjust to the port block
package afpm_pkg;
  // pin configuration nibble codes
  localparam logic [3:0] AFPM_CFG_ANALOG   = 4'h0;
  localparam logic [3:0] AFPM_CFG_OUT_PP   = 4'h1;
  localparam logic [3:0] AFPM_CFG_OUT_OD   = 4'h5;
  localparam logic [3:0] AFPM_CFG_ALT_PP   = 4'h9;
  localparam logic [3:0] AFPM_CFG_ALT_OD   = 4'hd;
  // nibble positions within the config words
  localparam int AFPM_NIB_PA2 = 8;   // low word [11:8]
  localparam int AFPM_NIB_PA3 = 12;  // low word [15:12]
  localparam int AFPM_NIB_PA4 = 0;   // high word [3:0]
  localparam int AFPM_NIB_PA5 = 4;   // high word [7:4]
  localparam int AFPM_NIB_PA6 = 8;   // high word [11:8]
  localparam int AFPM_NIB_PB1 = 4;   // port b low word [7:4]
  // pin index of each line within the pin vectors
  localparam int AFPM_PIN_A2 = 0;
  localparam int AFPM_PIN_A3 = 1;
  localparam int AFPM_PIN_A4 = 2;
  localparam int AFPM_PIN_A5 = 3;
  localparam int AFPM_PIN_A6 = 4;
  localparam int AFPM_PIN_B1 = 5;
  // timer b remap bit positions
  localparam int AFPM_REMAP_CH1 = 4;
  localparam int AFPM_REMAP_CH2 = 5;
  localparam int AFPM_REMAP_CH4 = 7;
  // capture/compare enable bit positions (channel n at 4*(n-1))
  localparam int AFPM_CCE_CH1 = 0;
  localparam int AFPM_CCE_CH2 = 4;
  localparam int AFPM_CCE_CH3 = 8;
  localparam int AFPM_CCE_CH4 = 12;
  // serial controller mode codes
  localparam logic [1:0] AFPM_MODE_OFF  = 2'h0;
  localparam logic [1:0] AFPM_MODE_UART = 2'h1;
  localparam logic [1:0] AFPM_MODE_SPI  = 2'h2;
  localparam logic [1:0] AFPM_MODE_TWI  = 2'h3;
  localparam int AFPM_SPI_MASTER_BIT = 4;
  // pin drive sources, not used by the mux
  typedef enum logic [2:0] {
    AFPM_SRC_GPIO, AFPM_SRC_SPI, AFPM_SRC_TWI, AFPM_SRC_UART,
    AFPM_SRC_TIMER, AFPM_SRC_TRACE, AFPM_SRC_PKT
  } afpm_src_t;
endpackage : afpm_pkg

// *** hdl/afpm_pin_mux.sv ***
// Purpose: alternate-function selection for port a lines 2..6, port b lines 1..2
// Assumes: one clock, pins arrive asynchronously and are synchronised here
// Notes:   output selection is combinational; pin outputs are registered
//          pin reset synchroniser idles high, so rst_b alone never samples the strap

// What this block does
// RL1: ctrl2 spi clock out on line a2 gated
// RL2: ctrl2 slave clock input from line a2
// RL3: ctrl2 slave select input from line a3
// RL4: cpu trace clock on line a3 gated
// RL5: timer b ch2 out on a3 unremapped
// RL6: timer b ch2 capture from a3 unremapped
// RL7: analog inputs 4 and 5 on analog nibble
// RL8: packet trace frame on a4 without cpu trace
// RL9: packet trace data on a5 without cpu trace
// RL10: cpu trace bit2 on a4, four-wire trace
// RL11: cpu trace bit3 on a5, four-wire trace
// RL12: boot request sampled from a5 at reset
// RL13: timer a ch3 out on a6 when enabled
// RL14: timer a ch3 capture always from a6
// RL15: ctrl1 spi data out on b1 by role
// RL16: ctrl1 two-wire data open-drain on b1
// RL17: ctrl1 uart transmit on b1
// RL18: timer b ch1 out on b1 when remapped
// RL19: ctrl1 master data in from b2
// RL20: plain gpio when no alternate selected
// RL21: inputs always reach the gpio listeners of lines a2..a6, b1 and b2
module afpm_pin_mux
  import afpm_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        pin_reset_n,
  // configuration
  input  wire logic [15:0] port_a_low_config,
  input  wire logic [15:0] port_a_high_config,
  input  wire logic [15:0] port_b_low_config,
  input  wire logic [7:0]  timer_b_remap_bits,
  input  wire logic [15:0] timer_b_output_enables,
  input  wire logic [15:0] timer_a_output_enables,
  input  wire logic [1:0]  ctrl1_mode_select,
  input  wire logic        ctrl1_spi_role,
  input  wire logic [1:0]  ctrl2_mode_select,
  input  wire logic [7:0]  ctrl2_spi_config,
  input  wire logic        trace_enable,
  input  wire logic        trace_four_wire,
  input  wire logic        packet_trace_enable,
  // gpio data
  input  wire logic [5:0]  gpio_out,
  // peripheral outputs
  input  wire logic        ctrl2_spi_clock,
  input  wire logic        cpu_trace_clock,
  input  wire logic        timer_b_ch2,
  input  wire logic        packet_trace_frame,
  input  wire logic        packet_trace_data,
  input  wire logic        cpu_trace_bit2,
  input  wire logic        cpu_trace_bit3,
  input  wire logic        timer_a_ch3,
  input  wire logic        ctrl1_spi_master_out_slave_in,
  input  wire logic        ctrl1_spi_slave_out_master_in,
  input  wire logic        ctrl1_twowire_data,
  input  wire logic        ctrl1_uart_transmit,
  input  wire logic        timer_b_ch1,
  // pins, index 0..5 = a2,a3,a4,a5,a6,b1; b2 input only here
  input  wire logic [5:0]  pin_in,
  input  wire logic        port_b_line2_in,
  output logic      [5:0]  pin_out,
  output logic      [5:0]  pin_oe,
  output logic      [1:0]  analog_connect,
  // inputs to peripherals
  output logic             ctrl2_spi_slave_clock,
  output logic             ctrl2_slave_select_n,
  output logic             timer_b_ch2_capture,
  output logic             timer_a_ch3_capture,
  output logic             ctrl1_spi_master_in,
  output logic      [5:0]  gpio_in,
  output logic             port_b_line2_gpio_in,
  output logic             boot_loader_request_n
);

  localparam int PIN_N = 6;

  function automatic logic [3:0] nib(input logic [15:0] w, input int pos);
    nib = w[pos +: 4];
  endfunction : nib

  function automatic logic is_alt(input logic [3:0] n);
    is_alt = (n == AFPM_CFG_ALT_PP) || (n == AFPM_CFG_ALT_OD);
  endfunction : is_alt

  function automatic logic is_out(input logic [3:0] n);
    is_out = (n == AFPM_CFG_OUT_PP) || (n == AFPM_CFG_OUT_OD);
  endfunction : is_out

  function automatic logic is_od(input logic [3:0] n);
    is_od = (n == AFPM_CFG_OUT_OD) || (n == AFPM_CFG_ALT_OD);
  endfunction : is_od

  // drive level of one pin: alternate source first, then gpio, else released
  function automatic logic pin_level(input logic sel, input logic alt, input logic [3:0] n,
                                     input logic gpio);
    if (sel) begin
      pin_level = alt;
    end else if (is_out(n)) begin
      pin_level = gpio; // see RL20
    end else begin
      pin_level = 1'b0; // see RL20
    end
  endfunction : pin_level

  // open-drain pins only ever pull low, so the enable carries the data
  function automatic logic pin_enable(input logic sel, input logic alt, input logic [3:0] n,
                                      input logic gpio);
    if (sel) begin
      pin_enable = is_od(n) ? !alt : 1'b1; // see RL16
    end else if (is_out(n)) begin
      pin_enable = is_od(n) ? !gpio : 1'b1; // see RL20
    end else begin
      pin_enable = 1'b0;
    end
  endfunction : pin_enable

  // input synchronisers; every pin is asynchronous to clk
  logic [PIN_N-1:0] sync1;
  logic [PIN_N-1:0] sync2;
  logic             b2_sync1;
  logic             b2_sync2;
  logic             rst_sync1;
  logic             rst_sync2;
  logic             rst_seen;
  logic             boot_req;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
    end
  end

  // line b2 is input only in this block
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      b2_sync1 <= 1'b0;
      b2_sync2 <= 1'b0;
    end else begin
      b2_sync1 <= port_b_line2_in;
      b2_sync2 <= b2_sync1;
    end
  end

  // reset to the idle level so releasing rst_b is not taken for a pin reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync1 <= 1'b1;
      rst_sync2 <= 1'b1;
    end else begin
      rst_sync1 <= pin_reset_n;
      rst_sync2 <= rst_sync1;
    end
  end

  // synchronised pin levels
  wire line_a2 = sync2[AFPM_PIN_A2];
  wire line_a3 = sync2[AFPM_PIN_A3];
  wire line_a5 = sync2[AFPM_PIN_A5];
  wire line_a6 = sync2[AFPM_PIN_A6];
  wire line_b2 = b2_sync2;

  // strap follows the pin while pin reset is held and on the cycle after release,
  // then freezes so later use of the line as gpio cannot disturb it
  wire boot_window = !rst_sync2 || rst_seen;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_seen <= 1'b0;
    end else begin
      rst_seen <= !rst_sync2;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      boot_req <= 1'b1;
    end else if (boot_window) begin
      boot_req <= line_a5; // see RL12
    end
  end

  // decoded nibbles
  wire [3:0] cfg_a2 = nib(port_a_low_config, AFPM_NIB_PA2);
  wire [3:0] cfg_a3 = nib(port_a_low_config, AFPM_NIB_PA3);
  wire [3:0] cfg_a4 = nib(port_a_high_config, AFPM_NIB_PA4);
  wire [3:0] cfg_a5 = nib(port_a_high_config, AFPM_NIB_PA5);
  wire [3:0] cfg_a6 = nib(port_a_high_config, AFPM_NIB_PA6);
  wire [3:0] cfg_b1 = nib(port_b_low_config, AFPM_NIB_PB1);

  // timer conditions
  wire remap1 = timer_b_remap_bits[AFPM_REMAP_CH1];
  wire remap2 = timer_b_remap_bits[AFPM_REMAP_CH2];
  wire remap4 = timer_b_remap_bits[AFPM_REMAP_CH4];
  wire tb_ch1_en = timer_b_output_enables[AFPM_CCE_CH1];
  wire tb_ch2_en = timer_b_output_enables[AFPM_CCE_CH2];
  wire tb_ch4_en = timer_b_output_enables[AFPM_CCE_CH4];
  wire ta_ch3_en = timer_a_output_enables[AFPM_CCE_CH3];

  // serial controller roles
  wire c2_spi    = (ctrl2_mode_select == AFPM_MODE_SPI);
  wire c2_master = c2_spi && ctrl2_spi_config[AFPM_SPI_MASTER_BIT];
  wire c2_slave  = c2_spi && !ctrl2_spi_config[AFPM_SPI_MASTER_BIT];
  wire c1_spi    = (ctrl1_mode_select == AFPM_MODE_SPI);
  wire c1_twi    = (ctrl1_mode_select == AFPM_MODE_TWI);
  wire c1_uart   = (ctrl1_mode_select == AFPM_MODE_UART);
  wire c1_master = c1_spi && ctrl1_spi_role;

  // per-pin alternate drive selection
  // a timer channel that is disabled or moved away frees its pin
  wire a2_spi  = is_alt(cfg_a2) && c2_master && (!tb_ch4_en || remap4); // see RL1
  wire a3_tmr  = is_alt(cfg_a3) && !remap2 && tb_ch2_en;                // see RL5
  wire a3_trc  = is_alt(cfg_a3) && trace_enable && !a3_tmr;              // see RL4
  wire a4_trc  = is_alt(cfg_a4) && trace_enable && trace_four_wire;     // see RL10
  wire a4_pkt  = is_alt(cfg_a4) && !trace_enable && packet_trace_enable; // see RL8
  wire a5_trc  = is_alt(cfg_a5) && trace_enable && trace_four_wire;     // see RL11
  wire a5_pkt  = is_alt(cfg_a5) && !trace_enable && packet_trace_enable; // see RL9
  wire a6_tmr  = is_alt(cfg_a6) && ta_ch3_en;                           // see RL13
  wire b1_free = !tb_ch1_en || !remap1;
  wire b1_tmr  = is_alt(cfg_b1) && remap1 && tb_ch1_en;                 // see RL18
  wire b1_spi  = is_alt(cfg_b1) && c1_spi && b1_free;                   // see RL15
  wire b1_twi  = is_alt(cfg_b1) && c1_twi && b1_free;                   // see RL16
  wire b1_uart = is_alt(cfg_b1) && c1_uart && b1_free;                  // see RL17
  wire b1_spi_data = ctrl1_spi_role ? ctrl1_spi_master_out_slave_in
                                    : ctrl1_spi_slave_out_master_in;   // see RL15

  // alternate level per pin, by the priorities of the selections above
  wire a2_alt = ctrl2_spi_clock;
  wire a3_alt = a3_tmr ? timer_b_ch2 : cpu_trace_clock;
  wire a4_alt = a4_trc ? cpu_trace_bit2 : packet_trace_frame;
  wire a5_alt = a5_trc ? cpu_trace_bit3 : packet_trace_data;
  wire a6_alt = timer_a_ch3;
  wire b1_alt = b1_tmr ? timer_b_ch1
              : b1_spi ? b1_spi_data
              : b1_twi ? ctrl1_twowire_data
              : ctrl1_uart_transmit;

  // any selected alternate source owns the pin
  wire a2_sel = a2_spi;
  wire a3_sel = a3_tmr || a3_trc;
  wire a4_sel = a4_trc || a4_pkt;
  wire a5_sel = a5_trc || a5_pkt;
  wire a6_sel = a6_tmr;
  wire b1_sel = b1_tmr || b1_spi || b1_twi || b1_uart;

  // next pin drive
  wire [PIN_N-1:0] next_out;
  wire [PIN_N-1:0] next_oe;
  assign next_out[AFPM_PIN_A2] = pin_level(a2_sel, a2_alt, cfg_a2, gpio_out[AFPM_PIN_A2]);
  assign next_out[AFPM_PIN_A3] = pin_level(a3_sel, a3_alt, cfg_a3, gpio_out[AFPM_PIN_A3]);
  assign next_out[AFPM_PIN_A4] = pin_level(a4_sel, a4_alt, cfg_a4, gpio_out[AFPM_PIN_A4]);
  assign next_out[AFPM_PIN_A5] = pin_level(a5_sel, a5_alt, cfg_a5, gpio_out[AFPM_PIN_A5]);
  assign next_out[AFPM_PIN_A6] = pin_level(a6_sel, a6_alt, cfg_a6, gpio_out[AFPM_PIN_A6]);
  assign next_out[AFPM_PIN_B1] = pin_level(b1_sel, b1_alt, cfg_b1, gpio_out[AFPM_PIN_B1]);

  // enables; open-drain lines release instead of driving high
  assign next_oe[AFPM_PIN_A2] = pin_enable(a2_sel, a2_alt, cfg_a2, gpio_out[AFPM_PIN_A2]);
  assign next_oe[AFPM_PIN_A3] = pin_enable(a3_sel, a3_alt, cfg_a3, gpio_out[AFPM_PIN_A3]);
  assign next_oe[AFPM_PIN_A4] = pin_enable(a4_sel, a4_alt, cfg_a4, gpio_out[AFPM_PIN_A4]);
  assign next_oe[AFPM_PIN_A5] = pin_enable(a5_sel, a5_alt, cfg_a5, gpio_out[AFPM_PIN_A5]);
  assign next_oe[AFPM_PIN_A6] = pin_enable(a6_sel, a6_alt, cfg_a6, gpio_out[AFPM_PIN_A6]);
  assign next_oe[AFPM_PIN_B1] = pin_enable(b1_sel, b1_alt, cfg_b1, gpio_out[AFPM_PIN_B1]);

  // registered drive adds one cycle of latency to every alternate output
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_out <= '0;
    end else begin
      pin_out <= next_out;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_oe <= '0;
    end else begin
      pin_oe <= next_oe;
    end
  end

  // inputs: ungated listeners see the pin whatever drives it; gated ones idle inactive
  assign gpio_in               = sync2;                              // see RL21
  assign port_b_line2_gpio_in  = line_b2;                            // see RL21
  assign ctrl2_spi_slave_clock = c2_slave ? line_a2 : 1'b0;          // see RL2
  assign ctrl2_slave_select_n  = c2_slave ? line_a3 : 1'b1;          // see RL3
  assign timer_b_ch2_capture   = !remap2 ? line_a3 : 1'b0;           // see RL6
  assign timer_a_ch3_capture   = line_a6;                            // see RL14
  assign ctrl1_spi_master_in   = c1_master ? line_b2 : 1'b0;         // see RL19
  assign analog_connect        = {cfg_a5 == AFPM_CFG_ANALOG,
                                  cfg_a4 == AFPM_CFG_ANALOG};        // see RL7
  assign boot_loader_request_n = boot_req;                           // see RL12

endmodule : afpm_pin_mux

// *** testbench/afpm_pin_mux_asserts.sv ***
// Purpose: port-level checks for the pin mux
// Assumes: pin drive one cycle late, pin inputs two cycles late
// Notes:   pin input paths checked once the synchronisers hold fresh data
module afpm_pin_mux_asserts
  import afpm_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // configuration
  input wire logic [15:0] port_a_low_config,
  input wire logic [15:0] port_a_high_config,
  input wire logic [15:0] timer_b_output_enables,
  input wire logic [15:0] timer_a_output_enables,
  input wire logic [7:0]  timer_b_remap_bits,
  input wire logic [7:0]  ctrl2_spi_config,
  input wire logic [1:0]  ctrl2_mode_select,
  // gpio and pins
  input wire logic [5:0]  gpio_out,
  input wire logic [5:0]  pin_in,
  input wire logic [5:0]  pin_out,
  input wire logic [5:0]  pin_oe,
  input wire logic [5:0]  gpio_in,
  // peripheral sides
  input wire logic        timer_a_ch3,
  input wire logic        timer_b_ch2,
  input wire logic [1:0]  analog_connect,
  input wire logic        ctrl2_slave_select_n,
  input wire logic        timer_b_ch2_capture,
  input wire logic        timer_a_ch3_capture
);
  logic [1:0] age;
  wire        warm   = age == 2'h3;
  wire  [3:0] nib_a3 = port_a_low_config[AFPM_NIB_PA3 +: 4];
  wire  [3:0] nib_a6 = port_a_high_config[AFPM_NIB_PA6 +: 4];
  wire        free2  = !timer_b_remap_bits[AFPM_REMAP_CH2];
  // syncs still hold reset zeros for two edges
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      age <= 2'h0;
    else if (!warm)
      age <= age + 2'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a6_timer_out_a:
    assert property (nib_a6 == AFPM_CFG_ALT_PP && timer_a_output_enables[AFPM_CCE_CH3]
      |=> pin_out[4] == $past(timer_a_ch3) && pin_oe[4]) else $error("a6 timer drive wrong");
  a6_capture_a:
    assert property (warm |-> timer_a_ch3_capture == $past(pin_in[4], 2))
    else $error("a6 capture wrong");
  a3_timer_out_a:
    assert property (nib_a3 == AFPM_CFG_ALT_PP && free2 && timer_b_output_enables[AFPM_CCE_CH2]
      |=> pin_out[1] == $past(timer_b_ch2) && pin_oe[1]) else $error("a3 timer drive wrong");
  a3_capture_a:
    assert property (warm && free2 |-> timer_b_ch2_capture == $past(pin_in[1], 2))
    else $error("a3 capture wrong");
  analog_link_a:
    assert property (analog_connect == {port_a_high_config[7:4] == AFPM_CFG_ANALOG,
      port_a_high_config[3:0] == AFPM_CFG_ANALOG}) else $error("analog link wrong");
  slave_sel_a:
    assert property (warm && ctrl2_mode_select == AFPM_MODE_SPI && !ctrl2_spi_config[4]
      |-> ctrl2_slave_select_n == $past(pin_in[1], 2)) else $error("slave select wrong");
  gpio_drive_a:
    assert property (nib_a6 == AFPM_CFG_OUT_PP |=> pin_out[4] == $past(gpio_out[4])
      && pin_oe[4]) else $error("gpio drive wrong");
  gpio_input_a:
    assert property (warm |-> gpio_in == $past(pin_in, 2)) else $error("gpio input wrong");
  cover property (nib_a6 == AFPM_CFG_ALT_PP && timer_a_output_enables[AFPM_CCE_CH3]);
  cover property (nib_a3 == AFPM_CFG_ALT_PP && !free2);
  cover property (analog_connect == 2'h3);
endmodule : afpm_pin_mux_asserts

bind afpm_pin_mux afpm_pin_mux_asserts u_afpm_pin_mux_asserts (
  .clk                    (clk),
  .rst_b                  (rst_b),
  .port_a_low_config      (port_a_low_config),
  .port_a_high_config     (port_a_high_config),
  .timer_b_output_enables (timer_b_output_enables),
  .timer_a_output_enables (timer_a_output_enables),
  .timer_b_remap_bits     (timer_b_remap_bits),
  .ctrl2_spi_config       (ctrl2_spi_config),
  .ctrl2_mode_select      (ctrl2_mode_select),
  .gpio_out               (gpio_out),
  .pin_in                 (pin_in),
  .pin_out                (pin_out),
  .pin_oe                 (pin_oe),
  .gpio_in                (gpio_in),
  .timer_a_ch3            (timer_a_ch3),
  .timer_b_ch2            (timer_b_ch2),
  .analog_connect         (analog_connect),
  .ctrl2_slave_select_n   (ctrl2_slave_select_n),
  .timer_b_ch2_capture    (timer_b_ch2_capture),
  .timer_a_ch3_capture    (timer_a_ch3_capture)
);

// *** testbench/afpm_board.sv ***
// Purpose: board lines around the mux pins
// Assumes: bench sets the level of every released line
// Notes:   released lines show the board level, never a stale drive
module afpm_board (
  // mux side
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  // board side
  input wire logic [5:0] ext,
  output logic     [5:0] pin_in
);
  assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule : afpm_board

// *** testbench/tb_top.sv ***
// Purpose: directed scenarios for the pin mux
// Assumes: inputs change on falling edges
// Notes:   three cycles settle both registered and synchronised paths
module tb_top;
  import afpm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_b, prn, role, ten, t4w, pte, b2;
  logic [15:0] cal, cah, cbl, tbe, tae;
  logic [7:0]  rmp, c2c;
  logic [1:0]  m1, m2, an;
  logic [5:0]  gout, ext, pin, pout, poe, gin;
  logic [12:0] per;
  logic        sclk2, ss2, capb2, capa3, mi1, b2g, boot;
  int          n_errors = 0;
  int          tests_run = 0;
  afpm_pin_mux u_afpm_pin_mux (.clk(clk), .rst_b(rst_b), .pin_reset_n(prn),
    .port_a_low_config(cal), .port_a_high_config(cah), .port_b_low_config(cbl),
    .timer_b_remap_bits(rmp), .timer_b_output_enables(tbe), .timer_a_output_enables(tae),
    .ctrl1_mode_select(m1), .ctrl1_spi_role(role), .ctrl2_mode_select(m2),
    .ctrl2_spi_config(c2c), .trace_enable(ten), .trace_four_wire(t4w),
    .packet_trace_enable(pte), .gpio_out(gout), .ctrl2_spi_clock(per[0]),
    .cpu_trace_clock(per[1]), .timer_b_ch2(per[2]), .packet_trace_frame(per[3]),
    .packet_trace_data(per[4]), .cpu_trace_bit2(per[5]), .cpu_trace_bit3(per[6]),
    .timer_a_ch3(per[7]), .ctrl1_spi_master_out_slave_in(per[8]),
    .ctrl1_spi_slave_out_master_in(per[9]), .ctrl1_twowire_data(per[10]),
    .ctrl1_uart_transmit(per[11]), .timer_b_ch1(per[12]), .pin_in(pin),
    .port_b_line2_in(b2), .pin_out(pout), .pin_oe(poe), .analog_connect(an),
    .ctrl2_spi_slave_clock(sclk2), .ctrl2_slave_select_n(ss2),
    .timer_b_ch2_capture(capb2), .timer_a_ch3_capture(capa3),
    .ctrl1_spi_master_in(mi1), .gpio_in(gin), .port_b_line2_gpio_in(b2g),
    .boot_loader_request_n(boot));
  afpm_board u_afpm_board (.pin_out(pout), .pin_oe(poe), .ext(ext), .pin_in(pin));
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // every pin a plain input, board pulled high
  task automatic idle();
    {cal, cah, cbl} = {3{16'h4444}};
    {tbe, tae, rmp, c2c, m1, m2} = '0;
    {role, ten, t4w, pte, b2, per, gout} = '0;
    ext = 6'h3f;
  endtask : idle
  task automatic t_gpio();
    idle();
    {cal, cah, cbl, gout} = {16'h1144, 16'h4111, 16'h4414, 6'h2a};
    step(3);
    chk({2'h0, pout}, 8'h2a);
    chk({2'h0, poe}, 8'h3f);
    chk({2'h0, gin}, 8'h2a);
    {cah[11:8], gout[4]} = {AFPM_CFG_OUT_OD, 1'b0};
    step(1);
    chk({6'h0, pout[4], poe[4]}, 8'h1);
  endtask : t_gpio
  task automatic t_a6();
    idle();
    {cah[11:8], tae[AFPM_CCE_CH3], per[7]} = {AFPM_CFG_ALT_PP, 2'b11};
    step(3);
    chk({5'h0, pout[4], poe[4], capa3}, 8'h7);
    {cah, ext[4]} = {16'h4444, 1'b0};
    step(3);
    chk({7'h0, capa3}, 8'h0);
  endtask : t_a6
  task automatic t_a3();
    idle();
    {cal[15:12], tbe[AFPM_CCE_CH2], per[2]} = {AFPM_CFG_ALT_PP, 2'b11};
    step(3);
    chk({6'h0, pout[1], capb2}, 8'h3);
    {rmp[AFPM_REMAP_CH2], ten, per} = {2'b11, 13'h2};
    step(3);
    chk({6'h0, pout[1], capb2}, 8'h2);
  endtask : t_a3
  task automatic t_a45();
    idle();
    cah = 16'h4400;
    step(1);
    chk({6'h0, an}, 8'h3);
    {cah, pte, per} = {16'h4499, 1'b1, 13'h18};
    step(3);
    chk({4'h0, an, pout[3:2]}, 8'h3);
    {ten, t4w, per} = {2'b11, 13'h60};
    step(3);
    chk({6'h0, pout[3:2]}, 8'h3);
  endtask : t_a45
  task automatic t_spi2();
    idle();
    {m2, c2c, cal[11:8], per[0]} = {AFPM_MODE_SPI, 8'h10, AFPM_CFG_ALT_PP, 1'b1};
    step(3);
    chk({7'h0, pout[0]}, 8'h1);
    {cal, c2c, ext} = {16'h4444, 8'h00, 6'h3e};
    step(3);
    chk({6'h0, sclk2, ss2}, 8'h1);
    ext = 6'h3d;
    step(3);
    chk({6'h0, sclk2, ss2}, 8'h2);
  endtask : t_spi2
  task automatic t_b1();
    logic [1:0] md [4] = '{AFPM_MODE_UART, AFPM_MODE_SPI, AFPM_MODE_SPI, AFPM_MODE_TWI};
    int         ix [4] = '{11, 8, 9, 10};
    idle();
    b2 = 1'b1;
    for (int i = 0; i < 4; i++) begin
      {m1, role, per} = {md[i], i == 1, 13'h1 << ix[i]};
      cbl = (i == 3) ? 16'h44d4 : 16'h4494;
      step(3);
      chk({6'h0, pout[5], poe[5]}, {6'h0, 1'b1, i != 3});
      chk({7'h0, mi1}, {7'h0, i == 1});
      per = ~per;
      step(3);
      chk({6'h0, pout[5], poe[5]}, 8'h1);
    end
    {rmp, tbe, per, cbl} = {8'h10, 16'h1, 13'h1000, 16'h4494};
    step(3);
    chk({6'h0, pout[5], poe[5]}, 8'h3);
    chk({7'h0, b2g}, 8'h1);
  endtask : t_b1
  // request frozen once the pin reset has passed
  task automatic t_boot();
    idle();
    {prn, ext[3]} = 2'b00;
    step(4);
    chk({7'h0, boot}, 8'h0);
    prn = 1'b1;
    step(6);
    ext[3] = 1'b1;
    step(4);
    chk({7'h0, boot}, 8'h0);
    prn = 1'b0;
    step(4);
    chk({7'h0, boot}, 8'h1);
    prn = 1'b1;
  endtask : t_boot
  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    idle();
    {rst_b, prn} = 2'b01;
    step(2);
    rst_b = 1'b1;
    step(1);
    chk({7'h0, boot}, 8'h1);
    t_gpio();
    t_a6();
    t_a3();
    t_a45();
    t_spi2();
    t_b1();
    t_boot();
    finish_test();
  end
  // scenarios need about 80 cycles
  initial begin
    repeat (2000) @(posedge clk);
    n_errors++;
    finish_test();
  end
endmodule : tb_top
